//--- pkg/pwm3_fault_pkg.sv
// constants and types for the pwm channel 3 fault source selection block
package pwm3_fault_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  localparam logic [31:0] SRC_EN_OFFSET = 32'h0003006C;
  localparam logic [31:0] IRQ_STATUS_OFFSET = 32'h00030100;
  localparam logic [31:0] IRQ_CLEAR_OFFSET = 32'h00030104;
  localparam logic [31:0] IRQ_ENABLE_OFFSET = 32'h00030108;

  // ----------------------------------------------------------------
  // source enable register layout
  // ----------------------------------------------------------------
  localparam int SRC_W = 15;
  localparam int OUTB_LSB = 16;
  localparam int OUTA_LSB = 0;
  localparam int UNUSED_BIT = 15;
  // positions inside one 15-bit half
  localparam int DIGCMP_LSB = 11;
  localparam int PIN_LSB = 7;
  localparam int ANACMP_LSB = 0;

  localparam logic [31:0] SRC_EN_RESET = 32'h00000000;
  localparam logic [31:0] SRC_EN_WMASK = 32'h7FFF7FFF;

  // ----------------------------------------------------------------
  // interrupt layout
  // ----------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_FAULT_A_BIT = 0;
  localparam int IRQ_FAULT_B_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // field order matches one half of the enable register bit for bit
  typedef struct packed {
    logic [3:0] digcmp;
    logic [3:0] pin;
    logic [6:0] anacmp;
  } fault_src_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

//--- rtl/pwm3_fault_source_select.sv
// fault source selection and register bank for pwm channel 3 outputs a and b
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module pwm3_fault_source_select (
  input wire logic mclk,
  input wire logic resetn,
  input wire pwm3_fault_pkg::reg_req_s bus_req,
  output logic [31:0] rdata,
  input wire pwm3_fault_pkg::fault_src_s src,
  output logic fault_a,
  output logic fault_b,
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic src_hit(input pwm3_fault_pkg::fault_src_s s,
                                   input logic [14:0] en);
    src_hit = |(s & en);
  endfunction

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] off);
    addr_is = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] en_q;
  logic [31:0] en_d;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] irqen_q;
  logic [1:0] irqen_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic fault_a_q;
  logic fault_a_d;
  logic fault_b_q;
  logic fault_b_d;
  logic [14:0] en_a;
  logic [14:0] en_b;
  logic [1:0] rise;
  logic [1:0] clr;

  assign en_a = en_q[pwm3_fault_pkg::OUTA_LSB +: pwm3_fault_pkg::SRC_W];
  assign en_b = en_q[pwm3_fault_pkg::OUTB_LSB +: pwm3_fault_pkg::SRC_W];

  // ----------------------------------------------------------------
  // source enable register
  // ----------------------------------------------------------------
  always_comb
  begin
    en_d = en_q;
    if (bus_req.wr && addr_is(bus_req.addr, pwm3_fault_pkg::SRC_EN_OFFSET))
    begin
      // bits 31 and 15 never store, so they read zero and never gate a source
      en_d = bus_req.wdata & pwm3_fault_pkg::SRC_EN_WMASK;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      en_q <= pwm3_fault_pkg::SRC_EN_RESET;
    end
    else
    begin
      en_q <= en_d;
    end
  end

  // ----------------------------------------------------------------
  // fault combining
  // ----------------------------------------------------------------
  // registered for a clean output; costs one cycle of fault latency
  always_comb
  begin
    fault_b_d = src_hit(src, en_b);
    fault_a_d = src_hit(src, en_a);
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      fault_a_q <= 1'b0;
      fault_b_q <= 1'b0;
    end
    else
    begin
      fault_a_q <= fault_a_d;
      fault_b_q <= fault_b_d;
    end
  end

  assign fault_a = fault_a_q;
  assign fault_b = fault_b_q;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    rise = 2'h0;
    rise[pwm3_fault_pkg::IRQ_FAULT_A_BIT] = fault_a_d & ~fault_a_q;
    rise[pwm3_fault_pkg::IRQ_FAULT_B_BIT] = fault_b_d & ~fault_b_q;
    clr = 2'h0;
    if (bus_req.wr && addr_is(bus_req.addr, pwm3_fault_pkg::IRQ_CLEAR_OFFSET))
    begin
      clr = bus_req.wdata[pwm3_fault_pkg::IRQ_W-1:0];
    end
    // a new fault in the clearing cycle survives the clear
    status_d = (status_q & ~clr) | rise;
    irqen_d = irqen_q;
    if (bus_req.wr && addr_is(bus_req.addr, pwm3_fault_pkg::IRQ_ENABLE_OFFSET))
    begin
      irqen_d = bus_req.wdata[pwm3_fault_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      status_q <= pwm3_fault_pkg::IRQ_RESET;
      irqen_q <= pwm3_fault_pkg::IRQ_RESET;
    end
    else
    begin
      status_q <= status_d;
      irqen_q <= irqen_d;
    end
  end

  assign irq = |(status_q & irqen_q);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (bus_req.rd)
    begin
      if (addr_is(bus_req.addr, pwm3_fault_pkg::SRC_EN_OFFSET))
      begin
        rdata_d = en_q;
      end
      else if (addr_is(bus_req.addr, pwm3_fault_pkg::IRQ_STATUS_OFFSET))
      begin
        rdata_d = {30'h00000000, status_q};
      end
      else if (addr_is(bus_req.addr, pwm3_fault_pkg::IRQ_ENABLE_OFFSET))
      begin
        rdata_d = {30'h00000000, irqen_q};
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  logic src_wr;
  logic src_rd;
  assign src_wr = bus_req.wr && (bus_req.addr == pwm3_fault_pkg::SRC_EN_OFFSET);
  assign src_rd = bus_req.rd && (bus_req.addr == pwm3_fault_pkg::SRC_EN_OFFSET);

  outb_digcmp_gate_a: assert property (
    ((src.digcmp & en_q[30:27]) != 4'h0) |=> fault_b)
    else $error("enabled digital comparator did not raise output b fault");

  outb_pin_gate_a: assert property (
    ((src.pin & en_q[26:23]) != 4'h0) |=> fault_b)
    else $error("enabled fault pin did not raise output b fault");

  outb_anacmp_gate_a: assert property (
    ((src.anacmp & en_q[22:16]) != 7'h00) |=> fault_b)
    else $error("enabled analog comparator did not raise output b fault");

  outa_layout_a: assert property (
    ((src.digcmp & en_q[14:11]) != 4'h0 || (src.pin & en_q[10:7]) != 4'h0
      || (src.anacmp & en_q[6:0]) != 7'h00) |=> fault_a)
    else $error("enabled source did not raise output a fault");

  // the default disable would mask exactly the cycles this one watches
  reset_clears_a: assert property (
    @(posedge mclk) disable iff (1'b0)
    !resetn |=> (en_q == pwm3_fault_pkg::SRC_EN_RESET) && !fault_a && !fault_b)
    else $error("source enables not cleared by reset");

  write_readback_a: assert property (
    src_wr ##1 src_rd |=> rdata == ($past(bus_req.wdata, 2) & pwm3_fault_pkg::SRC_EN_WMASK))
    else $error("enable register read back differs from written value");

  unused_zero_a: assert property (
    src_rd |=> !rdata[15] && !rdata[31])
    else $error("unused enable bit read as one");

  only_enabled_a: assert property (
    ((src & en_q[30:16]) == 15'h0000 && (src & en_q[14:0]) == 15'h0000)
      |=> !fault_a && !fault_b)
    else $error("fault raised with no enabled source active");

  irq_level_a: assert property (
    ((rise & irqen_d) != 2'h0) |=> irq)
    else $error("enabled fault event did not raise the interrupt");

  set_wins_a: assert property (
    (fault_b_d && !fault_b_q) |=> status_q[1])
    else $error("output b fault event lost");

  cover_fault_b_c: cover property ((src.pin[0] && en_q[23]) ##1 fault_b);
  cover_fault_a_c: cover property ((src.anacmp[6] && en_q[6]) ##1 fault_a);
  cover_irq_c: cover property (irq ##1 !irq);

endmodule

`default_nettype wire

//--- verif/testbench.sv
// self-checking testbench for the pwm channel 3 fault source selection block
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  pwm3_fault_pkg::reg_req_s req = '0;
  pwm3_fault_pkg::fault_src_s src = '0;
  logic [31:0] rdata;
  logic fault_a;
  logic fault_b;
  logic irq;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 mclk = ~mclk;

  pwm3_fault_source_select i_pwm3_fault_source_select (
    .mclk(mclk),
    .resetn(resetn),
    .bus_req(req),
    .rdata(rdata),
    .src(src),
    .fault_a(fault_a),
    .fault_b(fault_b),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // run end, check, bus access and source drive tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe stays high one cycle, so back-to-back calls never collide
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge mclk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // write then read in the very next cycle; rdata must fall back to zero after
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge mclk);
    #1;
    check(rdata, 32'h0);
  endtask

  // fault outputs are registered: look one edge after the sources land
  task automatic drive_src(input logic [14:0] s, input logic a, input logic b);
    @(posedge mclk);
    src <= s;
    @(posedge mclk);
    #1;
    check({30'h0, fault_b, fault_a}, {30'h0, b, a});
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rd(pwm3_fault_pkg::SRC_EN_OFFSET, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr_rd(pwm3_fault_pkg::SRC_EN_OFFSET, 32'hAAAA5555, 32'h2AAA5555);
    wr_rd(pwm3_fault_pkg::SRC_EN_OFFSET, 32'hFFFFFFFF, 32'h7FFF7FFF);
    drive_src(15'h7FFF, 1'b1, 1'b1);
    wr(pwm3_fault_pkg::SRC_EN_OFFSET, 32'h00008000);
    drive_src(15'h7FFF, 1'b0, 1'b0);
    // one enable at a time: every other source active must stay silent
    for (int h = 0; h < 2; h++)
      for (int i = 0; i < 15; i++)
      begin
        wr(pwm3_fault_pkg::SRC_EN_OFFSET, 32'h1 << (i + 16 * h));
        drive_src(~(15'h1 << i), 1'b0, 1'b0);
        drive_src(15'h1 << i, h == 0, h == 1);
      end
    // interrupt: raise, read, protect status, mask, clear
    wr(pwm3_fault_pkg::IRQ_CLEAR_OFFSET, 32'h3);
    wr(pwm3_fault_pkg::IRQ_ENABLE_OFFSET, 32'h3);
    rd(pwm3_fault_pkg::IRQ_ENABLE_OFFSET, 32'h3);
    rd(pwm3_fault_pkg::IRQ_STATUS_OFFSET, 32'h0);
    wr(pwm3_fault_pkg::SRC_EN_OFFSET, 32'h00800000);
    drive_src(15'h0080, 1'b0, 1'b1);
    check({31'h0, irq}, 32'h1);
    rd(pwm3_fault_pkg::IRQ_STATUS_OFFSET, 32'h2);
    wr(pwm3_fault_pkg::IRQ_STATUS_OFFSET, 32'h0);
    rd(pwm3_fault_pkg::IRQ_STATUS_OFFSET, 32'h2);
    wr(pwm3_fault_pkg::IRQ_ENABLE_OFFSET, 32'h1);
    #1;
    check({31'h0, irq}, 32'h0);
    wr(pwm3_fault_pkg::IRQ_CLEAR_OFFSET, 32'h2);
    rd(pwm3_fault_pkg::IRQ_STATUS_OFFSET, 32'h0);
    rd(pwm3_fault_pkg::IRQ_CLEAR_OFFSET, 32'h0);
    rd(32'h00030000, 32'h0);
    // second reset in mid-run with sources still active
    wr(pwm3_fault_pkg::SRC_EN_OFFSET, 32'h7FFF7FFF);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(pwm3_fault_pkg::SRC_EN_OFFSET, 32'h0);
    drive_src(15'h7FFF, 1'b0, 1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
